// file: design/ddr_power_state.v
// What this block does
// - Clock-enable sampled each rising edge; transitions other than self-refresh exit use previous and current samples.
// - Enable fall with deselect or no-operation enters active or precharge power-down.
// - Refresh with enable falling from all idle enters self-refresh; held while low.
// - No refresh in power-down; controller limits its duration.
// - No termination in self-refresh; termination never alters power states.
// - Write byte stored only when its mask is low.
// - Chip select high ignores commands; operations in progress continue.
// - Chip select low with strobes and write enable high is a no-operation.
// - Mode load picks register by bank address, stores address value.
// - Activate opens row until precharge; precharge before another row.
// - Read starts at column on low ten address bits; bit 10 selects auto-precharge.
// - Read auto-precharge closes row after burst; otherwise (writes included) row stays open.
// - Reads and writes registered internally after the additive latency.
// - Commands decoded from chip select, strobes and enable at the rising edge.
// - Self-refresh exit accepted without relying on clocks during self-refresh.
`timescale 1ns/1ps
`default_nettype none
`include "ddr_power_defs.vh"
module ddr_power_state
(
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        clock_en_i,
  input  wire        mem_clock_enable_i,
  input  wire        chip_select_n_i,
  input  wire        row_strobe_n_i,
  input  wire        column_strobe_n_i,
  input  wire        write_enable_n_i,
  input  wire [2:0]  bank_addr_i,
  input  wire [14:0] addr_i,
  input  wire        termination_control_i,
  input  wire [1:0]  write_byte_mask_i,
  input  wire        write_data_valid_i,
  input  wire [15:0] write_data_i,
  output reg  [2:0]  power_state_o,
  output reg  [7:0]  bank_open_o,
  output reg  [14:0] mode_reg_0_o,
  output reg  [14:0] mode_reg_1_o,
  output reg  [14:0] mode_reg_2_o,
  output reg  [14:0] mode_reg_3_o,
  output reg         read_start_o,
  output reg  [2:0]  read_bank_o,
  output reg  [9:0]  read_column_o,
  output reg         write_start_o,
  output reg  [15:0] stored_data_o,
  output reg         termination_active_o,
  output reg         read_allowed_o
);
  localparam ST_ACTIVE       = 3'b001;
  localparam ST_POWER_DOWN   = 3'b010;
  localparam ST_SELF_REFRESH = 3'b100;

  // Pin synchronisers; the first stage is read only by the second
  reg [1:0] cke_sync;
  reg [1:0] cs_sync;
  reg [1:0] ras_sync;
  reg [1:0] cas_sync;
  reg [1:0] we_sync;
  reg [1:0] odt_sync;
  reg [2:0]  ba_meta;
  reg [2:0]  ba_sync;
  reg [14:0] addr_meta;
  reg [14:0] addr_sync;
  reg [1:0]  mask_meta;
  reg [1:0]  mask_sync;
  reg [15:0] data_meta;
  reg [15:0] data_sync;
  reg [1:0]  dvalid_sync;

  reg        cke_prev;
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [7:0]  burst_left;
  reg [7:0]  exit_count;
  reg [3:0]  busy_count;
  reg        auto_pre_pending;
  reg [2:0]  auto_pre_bank;

  wire cke_now = cke_sync[1];
  wire [3:0] cmd = {cs_sync[1], ras_sync[1], cas_sync[1], we_sync[1]};
  // Deselect or no-operation leaves work in progress alone
  wire idle_cmd = cs_sync[1] | (cmd == `CMD_NO_OPERATION);
  wire run_cmd  = cke_prev & cke_now & !cs_sync[1] & (state == ST_ACTIVE);
  wire all_idle = (bank_open_o == 8'h00);
  wire [2:0] additive_latency = (mode_reg_1_o[5:3] > `MAX_ADDITIVE_LATENCY) ?
                                `MAX_ADDITIVE_LATENCY : mode_reg_1_o[5:3];
  wire is_read  = run_cmd & (cmd == `CMD_READ);
  wire is_write = run_cmd & (cmd == `CMD_WRITE);
  wire        late_valid;
  wire [14:0] late_payload;
  wire        late_read = late_valid & late_payload[14];

  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cke_sync    <= 2'h0;
      cs_sync     <= 2'h3;
      ras_sync    <= 2'h3;
      cas_sync    <= 2'h3;
      we_sync     <= 2'h3;
      odt_sync    <= 2'h0;
      ba_meta     <= 3'h0;
      ba_sync     <= 3'h0;
      addr_meta   <= 15'h0000;
      addr_sync   <= 15'h0000;
      mask_meta   <= 2'h3;
      mask_sync   <= 2'h3;
      data_meta   <= 16'h0000;
      data_sync   <= 16'h0000;
      dvalid_sync <= 2'h0;
    end
    else if (clock_en_i)
    begin
      cke_sync    <= {cke_sync[0], mem_clock_enable_i};
      cs_sync     <= {cs_sync[0], chip_select_n_i};
      ras_sync    <= {ras_sync[0], row_strobe_n_i};
      cas_sync    <= {cas_sync[0], column_strobe_n_i};
      we_sync     <= {we_sync[0], write_enable_n_i};
      odt_sync    <= {odt_sync[0], termination_control_i};
      ba_meta     <= bank_addr_i;
      ba_sync     <= ba_meta;
      addr_meta   <= addr_i;
      addr_sync   <= addr_meta;
      mask_meta   <= write_byte_mask_i;
      mask_sync   <= mask_meta;
      data_meta   <= write_data_i;
      data_sync   <= data_meta;
      dvalid_sync <= {dvalid_sync[0], write_data_valid_i};
    end
  end

  // Power state from the pair of enable samples (self-refresh exit uses only the current one); termination is not consulted
  always @*
  begin
    next_state = state;
    case (state)
      ST_ACTIVE:
        if (cke_prev && !cke_now)
        begin
          if (cmd == `CMD_REFRESH && all_idle && busy_count == 4'h0)
            next_state = ST_SELF_REFRESH;
          else if (idle_cmd)
            next_state = ST_POWER_DOWN;
        end
      ST_POWER_DOWN:
        if (!cke_prev && cke_now && idle_cmd)
          next_state = ST_ACTIVE;
      ST_SELF_REFRESH:
        // Exit needs only the enable level, not clock activity inside self-refresh
        if (cke_now)
          next_state = ST_ACTIVE;
      default:
        next_state = ST_ACTIVE;
    endcase
  end

  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cke_prev         <= 1'b0;
      state            <= ST_ACTIVE;
      power_state_o    <= ST_ACTIVE;
      bank_open_o      <= 8'h00;
      mode_reg_0_o     <= `RESET_MODE_VALUE;
      mode_reg_1_o     <= `RESET_MODE_VALUE;
      mode_reg_2_o     <= `RESET_MODE_VALUE;
      mode_reg_3_o     <= `RESET_MODE_VALUE;
      read_start_o     <= 1'b0;
      read_bank_o      <= 3'h0;
      read_column_o    <= 10'h000;
      write_start_o    <= 1'b0;
      stored_data_o    <= 16'h0000;
      termination_active_o <= 1'b0;
      read_allowed_o   <= 1'b1;
      burst_left       <= 8'h00;
      exit_count       <= 8'h00;
      busy_count       <= 4'h0;
      auto_pre_pending <= 1'b0;
      auto_pre_bank    <= 3'h0;
    end
    else if (clock_en_i)
    begin
      cke_prev      <= cke_now;
      state         <= next_state;
      power_state_o <= next_state;
      read_start_o  <= late_read;
      write_start_o <= late_valid & !late_payload[14];
      termination_active_o <= odt_sync[1] & (next_state != ST_SELF_REFRESH);
      if (busy_count != 4'h0)
        busy_count <= busy_count - 4'h1;
      // Read exit delay counted from self-refresh exit
      if (state == ST_SELF_REFRESH && next_state == ST_ACTIVE)
      begin
        exit_count     <= `SELF_REFRESH_EXIT_READ_DELAY;
        read_allowed_o <= 1'b0;
      end
      else if (exit_count != 8'h00)
      begin
        exit_count     <= exit_count - 8'h01;
        read_allowed_o <= (exit_count == 8'h01);
      end
      if (run_cmd)
      begin
        case (cmd)
          `CMD_MODE_LOAD:
          begin
            busy_count <= `BURST_CLOCKS;
            case (ba_sync[1:0])
              2'h0: mode_reg_0_o <= addr_sync;
              2'h1: mode_reg_1_o <= addr_sync;
              2'h2: mode_reg_2_o <= addr_sync;
              default: mode_reg_3_o <= addr_sync;
            endcase
          end
          `CMD_ACTIVATE:
            bank_open_o[ba_sync] <= 1'b1;
          `CMD_PRECHARGE:
          begin
            busy_count <= `BURST_CLOCKS;
            if (addr_sync[`AUTO_PRECHARGE_BIT])
              bank_open_o <= 8'h00;
            else
              bank_open_o[ba_sync] <= 1'b0;
          end
          // No-operation must not stall the busy countdown
          default:
            busy_count <= (busy_count != 4'h0) ? busy_count - 4'h1 : 4'h0;
        endcase
      end
      if (is_read | is_write)
        busy_count <= `BURST_CLOCKS + {1'b0, additive_latency};
      // Internal read registration after the additive latency
      if (late_read)
      begin
        read_bank_o   <= late_payload[13:11];
        read_column_o <= late_payload[9:0];
        burst_left    <= {4'h0, `BURST_CLOCKS};
        auto_pre_pending <= late_payload[`AUTO_PRECHARGE_BIT];
        auto_pre_bank <= late_payload[13:11];
      end
      else if (burst_left != 8'h00)
      begin
        burst_left <= burst_left - 8'h01;
        // Row closes only once the burst has drained
        if (burst_left == 8'h01 && auto_pre_pending)
        begin
          bank_open_o[auto_pre_bank] <= 1'b0;
          auto_pre_pending <= 1'b0;
        end
      end
      // Masked bytes keep their previous value
      if (dvalid_sync[1])
      begin
        if (!mask_sync[0])
          stored_data_o[7:0] <= data_sync[7:0];
        if (!mask_sync[1])
          stored_data_o[15:8] <= data_sync[15:8];
      end
    end
  end

  ddr_latency_pipe u_latency
  (
    .clock_i            (clock_i),
    .rst_n_i            (rst_n_i),
    .clock_en_i         (clock_en_i),
    .additive_latency_i (additive_latency),
    .valid_i            (is_read | is_write),
    .payload_i          ({is_read, ba_sync, addr_sync[10:0]}),
    .valid_o            (late_valid),
    .payload_o          (late_payload)
  );
endmodule // ddr_power_state
`default_nettype wire

// file: design/ddr_power_defs.vh
`ifndef DDR_POWER_DEFS_VH
`define DDR_POWER_DEFS_VH
// Command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_MODE_LOAD     4'h0
`define CMD_REFRESH       4'h1
`define CMD_PRECHARGE     4'h2
`define CMD_ACTIVATE      4'h3
`define CMD_WRITE         4'h4
`define CMD_READ          4'h5
`define CMD_NO_OPERATION  4'h7
// Field positions
`define AUTO_PRECHARGE_BIT 10
`define COLUMN_MSB         9
// Bank and width figures
`define NUM_BANKS          8
`define BANK_BITS          3
`define ROW_BITS           15
`define BYTE_LANES         2
// Burst length in clocks (four beats on two edges)
`define BURST_CLOCKS       4'h2
// Read exit delay after self-refresh, in clocks
`define SELF_REFRESH_EXIT_READ_DELAY 8'hC8
// Minimum hold of the clock-enable level, in edges
`define CLOCK_ENABLE_MIN_HOLD 2'h3
// Largest additive latency
`define MAX_ADDITIVE_LATENCY 3'h6
// Reset values
`define RESET_MODE_VALUE 15'h0000
`endif

// file: design/ddr_latency_pipe.v
`timescale 1ns/1ps
`default_nettype none
module ddr_latency_pipe
(
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        clock_en_i,
  input  wire [2:0]  additive_latency_i,
  input  wire        valid_i,
  input  wire [14:0] payload_i,
  output reg         valid_o,
  output reg  [14:0] payload_o
);
  reg [5:0]  stage_valid;
  reg [14:0] stage_data [0:5];
  integer k;

  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      stage_valid <= 6'h00;
      for (k = 0; k < 6; k = k + 1)
        stage_data[k] <= 15'h0000;
    end
    else if (clock_en_i)
    begin
      stage_valid <= {stage_valid[4:0], valid_i};
      stage_data[0] <= payload_i;
      for (k = 1; k < 6; k = k + 1)
        stage_data[k] <= stage_data[k-1];
    end
  end

  // Zero latency passes straight through
  always @*
  begin
    if (additive_latency_i == 3'h0)
    begin
      valid_o   = valid_i;
      payload_o = payload_i;
    end
    else
    begin
      valid_o   = stage_valid[additive_latency_i - 3'h1];
      payload_o = stage_data[additive_latency_i - 3'h1];
    end
  end
endmodule // ddr_latency_pipe
`default_nettype wire

// file: dv/ddr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddr_power_defs.vh"
module ddr_ctrl_model
(
  input  wire logic        clock_i,
  input  wire logic        req_cke_i,
  input  wire logic [3:0]  req_cmd_i,
  input  wire logic [2:0]  req_bank_i,
  input  wire logic [14:0] req_addr_i,
  output var  logic        cke_o,
  output var  logic [3:0]  cmd_o,
  output var  logic [2:0]  bank_o,
  output var  logic [14:0] addr_o
);
  logic [1:0] hold = 2'h0;
  logic       chg;
  initial
  begin
    cke_o = 1'b1;
    cmd_o = `CMD_NO_OPERATION;
    bank_o = 3'h0;
    addr_o = 15'h0000;
  end
  always @(negedge clock_i)
  begin
    chg = (req_cke_i != cke_o) && (hold == 2'h0);
    if (chg)
      cke_o <= req_cke_i;
    hold <= chg ? 2'h2 : (hold != 2'h0) ? hold - 2'h1 : 2'h0;
    // Refresh on a falling edge is the one command allowed at a change
    if ((chg || !cke_o) && !(chg && !req_cke_i && req_cmd_i == `CMD_REFRESH))
      cmd_o <= `CMD_NO_OPERATION;
    else
      cmd_o <= req_cmd_i;
    bank_o <= req_bank_i;
    // Address is meaningless on a no-operation, so keep it moving
    addr_o <= (req_cmd_i == `CMD_NO_OPERATION) ? ~addr_o : req_addr_i;
  end
endmodule // ddr_ctrl_model
`default_nettype wire

// file: dv/ddr_power_state_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_power_state_chk
(
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] power_state_o,
  input  wire logic [7:0] bank_open_o,
  input  wire logic       read_start_o,
  input  wire logic [2:0] read_bank_o,
  input  wire logic       termination_active_o,
  input  wire logic       read_allowed_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_hot; $onehot(power_state_o); endproperty
  a_hot: assert property (p_hot) else $error("state not one-hot");
  property p_pd; $rose(power_state_o[1]) |-> $past(power_state_o[0]); endproperty
  a_pd: assert property (p_pd) else $error("power-down not from active");
  property p_sr; $rose(power_state_o[2]) |-> bank_open_o == 8'h00; endproperty
  a_sr: assert property (p_sr) else $error("self-refresh with open bank");
  property p_keep; power_state_o[1] && $past(power_state_o[1]) |-> $stable(bank_open_o); endproperty
  a_keep: assert property (p_keep) else $error("banks changed in power-down");
  property p_term; power_state_o[2] |-> !termination_active_o; endproperty
  a_term: assert property (p_term) else $error("termination in self-refresh");
  property p_rd; read_start_o |-> bank_open_o[read_bank_o] && power_state_o[0]; endproperty
  a_rd: assert property (p_rd) else $error("read on closed bank");
  property p_lock; $fell(power_state_o[2]) |=> !read_allowed_o [*8]; endproperty
  a_lock: assert property (p_lock) else $error("read allowed too early");
  property p_free; $fell(power_state_o[2]) |-> ##199 !read_allowed_o ##1 read_allowed_o; endproperty
  a_free: assert property (p_free) else $error("read exit delay wrong");
endmodule // ddr_power_state_chk
bind ddr_power_state ddr_power_state_chk i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .power_state_o(power_state_o), .bank_open_o(bank_open_o), .read_start_o(read_start_o),
  .read_bank_o(read_bank_o), .termination_active_o(termination_active_o),
  .read_allowed_o(read_allowed_o));
`default_nettype wire

// file: dv/ddr_power_state_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddr_power_defs.vh"
`define CHK(n, e, a) begin comparisons++; if ((e) !== (a)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module ddr_power_state_tb;
  logic clock_i = 1'b0, rst_n_i = 1'b0, rcke = 1'b1, term = 1'b0, wv = 1'b0, cke, rs, ws, ta, ra;
  logic [3:0] rcmd = `CMD_NO_OPERATION, cmd;
  logic [2:0] rbank = 3'h0, bank, ps, rb, b;
  logic [14:0] raddr = 15'h0000, addr, m0, m1, m2, m3, v;
  logic [14:0] mr [0:3];
  logic [1:0] mask = 2'h0;
  logic [15:0] wd = 16'h0000, sd, sm, d;
  logic [7:0] bo, om;
  logic [9:0] rc;
  integer failures = 0, comparisons = 0, seed = 32'hddc9, i, lat, base, n;
  always #5 clock_i = ~clock_i;
  ddr_ctrl_model i_ctrl (.clock_i(clock_i), .req_cke_i(rcke), .req_cmd_i(rcmd),
    .req_bank_i(rbank), .req_addr_i(raddr), .cke_o(cke), .cmd_o(cmd), .bank_o(bank), .addr_o(addr));
  ddr_power_state i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .clock_en_i(1'b1),
    .mem_clock_enable_i(cke), .chip_select_n_i(cmd[3]), .row_strobe_n_i(cmd[2]),
    .column_strobe_n_i(cmd[1]), .write_enable_n_i(cmd[0]), .bank_addr_i(bank), .addr_i(addr),
    .termination_control_i(term), .write_byte_mask_i(mask), .write_data_valid_i(wv),
    .write_data_i(wd), .power_state_o(ps), .bank_open_o(bo), .mode_reg_0_o(m0),
    .mode_reg_1_o(m1), .mode_reg_2_o(m2), .mode_reg_3_o(m3), .read_start_o(rs),
    .read_bank_o(rb), .read_column_o(rc), .write_start_o(ws), .stored_data_o(sd),
    .termination_active_o(ta), .read_allowed_o(ra));
  task automatic close_out;
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic go(input logic k, input [3:0] c, input [2:0] bk, input [14:0] a);
    @(negedge clock_i);
    rcke <= k;
    rcmd <= c;
    rbank <= bk;
    raddr <= a;
    @(negedge clock_i);
    rcmd <= `CMD_NO_OPERATION;
    // Long gap covers mode-load and burst busy time
    if (c != `CMD_READ && c != `CMD_WRITE)
      repeat (8) @(negedge clock_i);
  endtask
  task automatic chk_all;
    `CHK("bank_open", om, bo)
    `CHK("mode_reg_0", mr[0], m0)
    `CHK("mode_reg_1", mr[1], m1)
    `CHK("mode_reg_2", mr[2], m2)
    `CHK("mode_reg_3", mr[3], m3)
    `CHK("stored_data", sm, sd)
  endtask
  task automatic rd(input [3:0] c, input [14:0] a);
    go(1'b1, c, b, a);
    lat = 0;
    while (((c == `CMD_READ) ? rs : ws) !== 1'b1 && lat < 40)
    begin
      @(negedge clock_i);
      lat++;
    end
    if (lat == 40)
    begin
      failures++;
      close_out();
    end
    if (c == `CMD_READ)
    begin
      `CHK("read_bank", b, rb)
      `CHK("read_column", a[9:0], rc)
    end
    if (a[10] && c == `CMD_READ)
      om[b] = 1'b0;
    repeat (8) @(negedge clock_i);
  endtask
  initial
  begin
    om = 8'h00;
    sm = 16'h0000;
    for (i = 0; i < 4; i++)
      mr[i] = 15'h0000;
    repeat (2) @(negedge clock_i);
    rst_n_i <= 1'b1;
    repeat (6) @(negedge clock_i);
    `CHK("power_state", 3'h1, ps)
    `CHK("read_allowed", 1'b1, ra)
    chk_all();
    for (i = 0; i < 4; i++)
    begin
      v = $random(seed);
      if (i == 1)
        v[5:3] = 3'h0;
      go(1'b1, `CMD_MODE_LOAD, i[2:0], v);
      mr[i] = v;
    end
    go(1'b1, 4'hB, 3'h2, 15'h0011);
    chk_all();
    for (i = 0; i < 7; i += 3)
    begin
      mr[1][5:3] = i[2:0];
      go(1'b1, `CMD_MODE_LOAD, 3'h1, mr[1]);
      b = $random(seed);
      go(1'b1, `CMD_ACTIVATE, b, $random(seed));
      om[b] = 1'b1;
      v = $random(seed);
      v[10] = (i == 3);
      // Two synchroniser edges, then the registering edge, then the pulse
      base = 3;
      rd(`CMD_WRITE, {v[14:11], 1'b0, v[9:0]});
      `CHK("write_latency", base + i, lat)
      rd(`CMD_READ, v);
      `CHK("latency", base + i, lat)
      chk_all();
      go(1'b1, `CMD_PRECHARGE, 3'h0, 15'h0400);
      om = 8'h00;
    end
    for (i = 0; i < 4; i++)
    begin
      d = $random(seed);
      @(negedge clock_i);
      mask <= i[1:0];
      wd <= d;
      wv <= 1'b1;
      @(negedge clock_i);
      wv <= 1'b0;
      wd <= ~d;
      if (!i[0])
        sm[7:0] = d[7:0];
      if (!i[1])
        sm[15:8] = d[15:8];
      repeat (6) @(negedge clock_i);
      chk_all();
    end
    term <= 1'b1;
    go(1'b1, `CMD_ACTIVATE, 3'h5, 15'h0123);
    om[5] = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      go(1'b0, `CMD_NO_OPERATION, 3'h0, 15'h0000);
      `CHK("power_down", 3'h2, ps)
      go(1'b1, `CMD_NO_OPERATION, 3'h0, 15'h0000);
      `CHK("pd_exit", 3'h1, ps)
      chk_all();
      go(1'b1, `CMD_PRECHARGE, 3'h0, 15'h0400);
      om = 8'h00;
    end
    `CHK("termination", 1'b1, ta)
    go(1'b0, `CMD_REFRESH, 3'h0, 15'h0000);
    `CHK("self_refresh", 3'h4, ps)
    `CHK("sr_termination", 1'b0, ta)
    go(1'b1, `CMD_NO_OPERATION, 3'h0, 15'h0000);
    `CHK("sr_exit", 3'h1, ps)
    `CHK("read_lock", 1'b0, ra)
    n = 0;
    while (ra !== 1'b1 && n < 300)
    begin
      @(negedge clock_i);
      n++;
    end
    `CHK("read_free", 1'b1, ra)
    // Exit edge lies five clocks before the wait begins
    `CHK("read_delay", `SELF_REFRESH_EXIT_READ_DELAY - 5, n)
    if (n == 300)
      close_out();
    b = 3'h1;
    go(1'b1, `CMD_ACTIVATE, b, 15'h0042);
    om[b] = 1'b1;
    rd(`CMD_READ, 15'h0033);
    chk_all();
    close_out();
  end
endmodule // ddr_power_state_tb
`default_nettype wire
